/* File: rtl/three_pin_port.sv */
// Purpose: three pin general-purpose port with direction, latch and slave-port status
// Assumes: pins are asynchronous to pclk; slave-port transfer events come from logic on pclk
// Notes: the byte transfer engine and the converter itself live elsewhere
//
// Summary of operation
// - port is three bits wide; three pins individually set as input or output
// - a pin selected as analog reads zero in the pin-read register
// - direction bit one turns the pin driver off, pin is an input
// - direction bit zero drives the pin from its output latch bit
// - direction bits control drivers even when a pin is analog
// - after reset all three pins are analog inputs
// - latch register reads return latched values, not pin levels
// - direction register bit 3 is unimplemented and reads zero
// - direction bits 2..0 steer pins 2..0; one input, zero output
// - bit 7 reads one while a received word waits for the processor
// - bit 6 reads one while the output buffer holds an unread word
// - bit 5 sets on a write to an unread input word; software clears
// - bit 4 selects slave-port mode when one, plain port when zero
// - in slave-port mode pin0 is read strobe, pin1 write strobe, pin2 select
// - an output pin drives its latch value whatever the analog selection
// - the digital input path is off while a pin is analog, except for the slave-port strobes
// - bits 7..3 of pin-read and latch registers read zero
//
// The APB interface to the registers and the placing of the registers were chosen for this implementation.

`timescale 1ns/1ps
`default_nettype none

module three_pin_port
  import pin_port_pkg::*;
#(
  parameter int PINS = 3,
  parameter logic [3:0] LIMIT_PIN0 = ANALOG_LIMIT_PIN0,
  parameter logic [3:0] LIMIT_PIN1 = ANALOG_LIMIT_PIN1,
  parameter logic [3:0] LIMIT_PIN2 = ANALOG_LIMIT_PIN2
) (
  input wire logic pclk, // system clock, 20 MHz
  input wire logic presetn, // asynchronous reset, active low
  input wire logic clk_en, // freezes all state while low
  input wire logic psel, // apb select
  input wire logic penable, // apb access phase
  input wire logic pwrite, // apb direction, high for write
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic pready, // apb ready
  output logic [31:0] prdata, // apb read data, registered
  output logic pslverr, // apb error on unmapped address
  input wire logic [PINS-1:0] pin_in, // pin levels from the pads
  output logic [PINS-1:0] pin_out, // pin drive values
  output logic [PINS-1:0] pin_oe, // pin output enables, high while driving
  input wire logic host_write_done, // pulse: external write to the slave port ended
  input wire logic host_read_done, // pulse: external read of the slave port seen
  input wire logic input_word_taken, // pulse: processor read the received word
  input wire logic output_word_loaded, // pulse: processor wrote a word to send
  output host_strobes_t host_strobes, // synchronised strobes, inactive high outside slave mode
  output logic slave_port_select, // slave-port mode enabled
  output logic [3:0] pin_analog_select, // converter pin configuration field
  output logic [1:0] vref_select, // converter reference selection field
  output logic irq // level interrupt, high while an unmasked event is pending
);

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  // decides whether a pin is analog for the current configuration code
  function automatic logic is_analog(input logic [3:0] code, input logic [3:0] limit);
    is_analog = (code <= limit);
  endfunction

  // places a narrow field into the low bits of a bus word
  function automatic logic [31:0] to_word(input logic [7:0] value);
    to_word = {24'h000000, value};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // declarations

  apb_req_t req;
  logic [PINS-1:0] pin_sync1;
  logic [PINS-1:0] pin_sync2;
  logic [PINS-1:0] output_latch;
  logic [PINS-1:0] direction;
  logic [PINS-1:0] analog_pins;
  logic [PINS-1:0] pin_levels;
  slave_status_t status;
  logic [2:0] irq_status;
  logic [2:0] irq_mask;
  logic [2:0] irq_events;
  logic [7:0] direction_byte;
  logic capture_read;
  logic read_loaded;
  logic write_access;
  logic addr_mapped;
  logic next_input_word_full;
  logic next_output_word_full;
  logic next_input_overflow;
  logic [31:0] next_prdata;
  logic [7:0] wbyte;

  ////////////////////////////////////////////////////////////////////////////////
  // bus request and phase decode

  // gather the request fields that travel together
  assign req.addr = paddr;
  assign req.write = pwrite;
  assign req.wdata = pwdata;
  assign wbyte = req.wdata[7:0];

  // answer in the first access cycle; a setup edge lost to a freeze costs one wait state
  // without it a frozen setup edge would hand back the previous transfer's data
  assign pready = clk_en && (read_loaded || !penable);
  assign capture_read = clk_en && psel && !read_loaded;
  assign write_access = psel && penable && pready && req.write && addr_mapped;

  // marks that prdata already holds the word of the running transfer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      read_loaded <= 1'b0;
    end else if (clk_en) begin
      read_loaded <= psel && !(penable && pready);
    end
  end

  // address decode shared by write and error paths; the read mux decodes the address itself
  always_comb begin
    case (req.addr)
      OFS_PIN_LEVELS, OFS_OUTPUT_LATCH, OFS_DIRECTION,
      OFS_CONVERTER_CFG, OFS_IRQ_STATUS, OFS_IRQ_MASK: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  // unmapped addresses answer with an error and no effect
  assign pslverr = psel && penable && !addr_mapped;

  ////////////////////////////////////////////////////////////////////////////////
  // pin input synchronisers

  // two flip-flops before any logic looks at a pad
  // the first stage may go metastable, so only the second stage is read
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync1 <= '0;
      pin_sync2 <= '0;
    end else if (clk_en) begin
      pin_sync1 <= pin_in;
      pin_sync2 <= pin_sync1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // analog selection and digital input path

  // per-pin analog flag from the converter configuration field
  always_comb begin
    analog_pins[0] = is_analog(pin_analog_select, LIMIT_PIN0);
    analog_pins[1] = is_analog(pin_analog_select, LIMIT_PIN1);
    analog_pins[2] = is_analog(pin_analog_select, LIMIT_PIN2);
  end

  // analog pins read as zero; digital input buffer off
  assign pin_levels = pin_sync2 & ~analog_pins;

  ////////////////////////////////////////////////////////////////////////////////
  // pin drivers

  // each direction bit alone steers its driver, analog or not
  assign pin_oe = ~direction;
  assign pin_out = output_latch;

  ////////////////////////////////////////////////////////////////////////////////
  // output latch

  // written through either the pin-read or the latch address
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      output_latch <= RST_LATCH;
    end else if (write_access) begin
      if (req.addr == OFS_PIN_LEVELS || req.addr == OFS_OUTPUT_LATCH) begin
        output_latch <= wbyte[PINS-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // direction bits and slave-port select

  // direction resets to inputs; the mode bit resets to plain port
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction <= RST_DIRECTION;
      slave_port_select <= 1'b0;
    end else if (write_access && req.addr == OFS_DIRECTION) begin
      direction <= wbyte[DIR_LSB +: PINS];
      slave_port_select <= wbyte[POS_SLAVE_PORT_SELECT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // converter pin configuration

  // reset code leaves every pin analog
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_analog_select <= RST_PIN_ANALOG_SELECT;
      vref_select <= RST_VREF_SELECT;
    end else if (write_access && req.addr == OFS_CONVERTER_CFG) begin
      pin_analog_select <= wbyte[POS_PIN_ANALOG_SELECT +: 4];
      vref_select <= wbyte[POS_VREF_SELECT +: 2];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // slave-port status flags

  // set wins over clear in every flag except output-full, where host_read_done wins
  // overflow clears only on a direction write with bit 5 low
  always_comb begin
    next_input_word_full = status.input_word_full;
    next_output_word_full = status.output_word_full;
    next_input_overflow = status.input_overflow;
    if (input_word_taken) begin
      next_input_word_full = 1'b0;
    end
    if (host_write_done) begin
      next_input_word_full = 1'b1;
    end
    if (host_read_done) begin
      next_output_word_full = 1'b0;
    end
    if (output_word_loaded && !host_read_done) begin
      next_output_word_full = 1'b1;
    end
    if (write_access && req.addr == OFS_DIRECTION && !wbyte[POS_INPUT_OVERFLOW]) begin
      next_input_overflow = 1'b0;
    end
    if (host_write_done && status.input_word_full && !input_word_taken) begin
      next_input_overflow = 1'b1;
    end
  end

  // status flags register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status <= '0;
    end else if (clk_en) begin
      status.input_word_full <= next_input_word_full;
      status.output_word_full <= next_output_word_full;
      status.input_overflow <= next_input_overflow;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // strobe pins in slave-port mode

  // strobes come straight from synchronised pads, held inactive otherwise
  always_comb begin
    if (slave_port_select) begin
      host_strobes.read_n = pin_sync2[0];
      host_strobes.write_n = pin_sync2[1];
      host_strobes.select_n = pin_sync2[2];
    end else begin
      host_strobes.read_n = 1'b1;
      host_strobes.write_n = 1'b1;
      host_strobes.select_n = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt status and mask

  // events that raise sticky interrupt bits
  // overflow raises an event only on its rising edge
  always_comb begin
    irq_events = '0;
    irq_events[POS_IRQ_HOST_WRITE] = host_write_done;
    irq_events[POS_IRQ_HOST_READ] = host_read_done;
    irq_events[POS_IRQ_OVERFLOW] = next_input_overflow && !status.input_overflow;
  end

  // write one clears; a new event in the same cycle stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status <= '0;
    end else if (clk_en) begin
      if (write_access && req.addr == OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~wbyte[2:0]) | irq_events;
      end else begin
        irq_status <= irq_status | irq_events;
      end
    end
  end

  // interrupt mask register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= RST_IRQ_MASK;
    end else if (write_access && req.addr == OFS_IRQ_MASK) begin
      irq_mask <= wbyte[2:0];
    end
  end

  // level output, high while an unmasked bit is pending
  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////////
  // read data

  // direction/status byte; bit 3 has no storage
  always_comb begin
    direction_byte = '0;
    direction_byte[DIR_LSB +: PINS] = direction;
    direction_byte[POS_SLAVE_PORT_SELECT] = slave_port_select;
    direction_byte[POS_INPUT_OVERFLOW] = status.input_overflow;
    direction_byte[POS_OUTPUT_WORD_FULL] = status.output_word_full;
    direction_byte[POS_INPUT_WORD_FULL] = status.input_word_full;
  end

  // read mux; upper bits of the port registers stay zero
  always_comb begin
    case (req.addr)
      OFS_PIN_LEVELS: next_prdata = to_word({5'h00, pin_levels});
      OFS_OUTPUT_LATCH: next_prdata = to_word({5'h00, output_latch});
      OFS_DIRECTION: next_prdata = to_word(direction_byte);
      OFS_CONVERTER_CFG: next_prdata = to_word({2'h0, vref_select, pin_analog_select});
      OFS_IRQ_STATUS: next_prdata = to_word({5'h00, irq_status});
      OFS_IRQ_MASK: next_prdata = to_word({5'h00, irq_mask});
      default: next_prdata = 32'h00000000;
    endcase
  end

  // read data captured once per transfer, normally at the setup edge, stable until the next one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (capture_read) begin
      prdata <= req.write ? 32'h00000000 : next_prdata;
    end
  end

endmodule

`default_nettype wire

/* File: rtl/pin_port_pkg.sv */
// Purpose: shared constants and types of the three pin port block
// Assumes: apb slave with 32-bit data, one aligned word per register
// Notes: register bytes sit in the low eight bits, the bits above read as zero

package pin_port_pkg;

  // register byte addresses
  localparam logic [7:0] OFS_PIN_LEVELS = 8'h00;
  localparam logic [7:0] OFS_OUTPUT_LATCH = 8'h04;
  localparam logic [7:0] OFS_DIRECTION = 8'h08;
  localparam logic [7:0] OFS_CONVERTER_CFG = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // direction_and_slave_status field positions
  localparam int DIR_LSB = 0;
  localparam int POS_SLAVE_PORT_SELECT = 4;
  localparam int POS_INPUT_OVERFLOW = 5;
  localparam int POS_OUTPUT_WORD_FULL = 6;
  localparam int POS_INPUT_WORD_FULL = 7;

  // converter_pin_config field positions
  localparam int POS_PIN_ANALOG_SELECT = 0;
  localparam int POS_VREF_SELECT = 4;

  // interrupt status bit positions
  localparam int POS_IRQ_HOST_WRITE = 0;
  localparam int POS_IRQ_HOST_READ = 1;
  localparam int POS_IRQ_OVERFLOW = 2;

  // reset values
  localparam logic [2:0] RST_LATCH = 3'h0;
  localparam logic [2:0] RST_DIRECTION = 3'h7;
  localparam logic [3:0] RST_PIN_ANALOG_SELECT = 4'h0;
  localparam logic [1:0] RST_VREF_SELECT = 2'h0;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // pin_analog_select codes at or below which a pin stays analog
  localparam logic [3:0] ANALOG_LIMIT_PIN0 = 4'h9;
  localparam logic [3:0] ANALOG_LIMIT_PIN1 = 4'h8;
  localparam logic [3:0] ANALOG_LIMIT_PIN2 = 4'h7;

  // apb request as seen by the slave
  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic [31:0] wdata;
  } apb_req_t;

  // slave-port status flags
  typedef struct packed {
    logic input_word_full;
    logic output_word_full;
    logic input_overflow;
  } slave_status_t;

  // external strobes seen in slave-port mode, all active low
  typedef struct packed {
    logic select_n;
    logic write_n;
    logic read_n;
  } host_strobes_t;

endpackage

/* File: tb/pad_model.sv */
// Purpose: outside circuitry on the three port pads
// Assumes: no pull resistors; a released pad shows what the outside drives
// Notes: the bench sets ext_level to model what the outside drives
`timescale 1ns/1ps
`default_nettype none
module pad_model (
  input wire logic [2:0] pin_out, // drive values from the port
  input wire logic [2:0] pin_oe, // output enables from the port
  input wire logic [2:0] ext_level, // level driven by the outside
  output logic [2:0] pin_in // resolved pad level
);
  // a driven pad shows the port value, a released one the outside level
  always_comb begin
    for (int i = 0; i < 3; i++) pin_in[i] = pin_oe[i] ? pin_out[i] : ext_level[i];
  end
endmodule
`default_nettype wire

/* File: tb/three_pin_port_sva.sv */
// Purpose: port-level assertions for the three pin port
// Assumes: apb completion seen as psel, penable and pready high; pads synchronised by two flops
// Notes: bound to every instance of the port
`timescale 1ns/1ps
`default_nettype none
module three_pin_port_sva
  import pin_port_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic clk_en, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb access
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic pready, // apb ready
  input wire logic [31:0] prdata, // apb read data
  input wire logic [2:0] pin_in, // pad levels
  input wire logic [2:0] pin_out, // pad drive
  input wire logic [2:0] pin_oe, // pad enables
  input wire host_strobes_t host_strobes, // slave strobes
  input wire logic slave_port_select, // slave mode
  input wire logic [3:0] pin_analog_select // analog field
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  logic wr;
  // completed transfers
  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  chk_reset_state: assert property (
    $rose(presetn) |-> pin_oe == 3'h0 && pin_analog_select == 4'h0) else $error("pins not analog inputs after reset");
  chk_dir_write: assert property (
    wr && paddr == OFS_DIRECTION |=> pin_oe == ~$past(pwdata[2:0]) && slave_port_select == $past(pwdata[4]))
    else $error("direction write not applied");
  chk_latch_write: assert property (
    wr && (paddr == OFS_OUTPUT_LATCH || paddr == OFS_PIN_LEVELS) |=> pin_out == $past(pwdata[2:0]))
    else $error("latch write not driven");
  chk_dir_hold: assert property (
    !(wr && paddr == OFS_DIRECTION) |=> $stable(pin_oe)) else $error("drivers changed without direction write");
  chk_strobe_idle: assert property (
    !slave_port_select |-> host_strobes == 3'h7) else $error("strobes active outside slave mode");
  chk_strobe_map: assert property (
    slave_port_select && $past(clk_en) && $past(clk_en, 2) && $past(presetn, 2) |-> host_strobes == $past(pin_in, 2))
    else $error("strobes do not follow pads");
  chk_upper_zero: assert property (
    acc && !pwrite |-> prdata[31:8] == 24'h0 && (paddr != OFS_DIRECTION || !prdata[3])
    && (paddr > OFS_OUTPUT_LATCH || prdata[7:3] == 5'h0)) else $error("unimplemented bits read nonzero");
  chk_analog_zero: assert property (
    acc && !pwrite && paddr == OFS_PIN_LEVELS && pin_analog_select <= ANALOG_LIMIT_PIN2 |-> prdata[2:0] == 3'h0)
    else $error("analog pins read nonzero");
endmodule
bind three_pin_port three_pin_port_sva u_three_pin_port_sva (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .prdata, .pin_in, .pin_out, .pin_oe, .host_strobes, .slave_port_select, .pin_analog_select);
`default_nettype wire

/* File: tb/three_pin_port_tb_top.sv */
// Purpose: register-level tests of the three pin port
// Assumes: apb slave answering by pready, two idle cycles after each transfer settle the pad sync
// Notes: events come in as one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module three_pin_port_tb_top;
  import pin_port_pkg::*;
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, slave_port_select;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [2:0] pin_in, pin_out, pin_oe, ext;
  logic [3:0] ev, pin_analog_select;
  logic [1:0] vref_select;
  logic rerr;
  host_strobes_t host_strobes;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;
  ////////////////////////////////////////////////////////////////
  three_pin_port u_three_pin_port (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .host_write_done(ev[0]), .host_read_done(ev[1]),
    .input_word_taken(ev[2]), .output_word_loaded(ev[3]), .host_strobes(host_strobes),
    .slave_port_select(slave_port_select), .pin_analog_select(pin_analog_select), .vref_select(vref_select),
    .irq(irq));
  pad_model u_pad_model (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
  // clock and watchdog
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      test_done();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer: setup, access until pready, release, two idle cycles
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rdata, exp);
  endtask
  task automatic pulse(input logic [3:0] m);
    ev <= m;
    @(posedge pclk);
    ev <= 4'h0;
    @(posedge pclk);
  endtask
  task automatic set_ext(input logic [2:0] v);
    ext <= v;
    repeat (3) @(posedge pclk);
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata, ev, ext} = '0;
    clk_en = 1'b1;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    set_ext(3'h7);
    rdck(OFS_DIRECTION, 32'h7);
    rdck(OFS_CONVERTER_CFG, 32'h0);
    rdck(OFS_PIN_LEVELS, 32'h0);
    rdck(OFS_IRQ_MASK, 32'h0);
    $display("test reset done");
    set_ext(3'h0);
    wr(OFS_OUTPUT_LATCH, 32'hffff_fffa);
    rdck(OFS_OUTPUT_LATCH, 32'h2);
    wr(OFS_DIRECTION, 32'h5);
    check(32'(pin_oe), 32'h2);
    check(32'(pin_out), 32'h2);
    rdck(OFS_PIN_LEVELS, 32'h0);
    wr(OFS_CONVERTER_CFG, 32'h0a);
    rdck(OFS_PIN_LEVELS, 32'h2);
    wr(OFS_PIN_LEVELS, 32'h5);
    rdck(OFS_OUTPUT_LATCH, 32'h5);
    rdck(OFS_PIN_LEVELS, 32'h0);
    $display("test latch done");
    wr(OFS_DIRECTION, 32'h7);
    set_ext(3'h7);
    for (logic [3:0] c = 4'h7; c <= 4'ha; c++) begin
      wr(OFS_CONVERTER_CFG, {26'h0, 2'h3, c});
      rdck(OFS_CONVERTER_CFG, {26'h0, 2'h3, c});
      rdck(OFS_PIN_LEVELS, {29'h0, c > ANALOG_LIMIT_PIN2, c > ANALOG_LIMIT_PIN1, c > ANALOG_LIMIT_PIN0});
    end
    check(32'(vref_select), 32'h3);
    wr(OFS_CONVERTER_CFG, 32'h0);
    wr(OFS_DIRECTION, 32'h0);
    check(32'(pin_oe), 32'h7);
    $display("test analog done");
    wr(OFS_DIRECTION, 32'h17);
    rdck(OFS_DIRECTION, 32'h17);
    check(32'(slave_port_select), 32'h1);
    set_ext(3'h2);
    check(32'(host_strobes), 32'h2);
    wr(OFS_DIRECTION, 32'h7);
    check(32'(host_strobes), 32'h7);
    $display("test slave mode done");
    wr(OFS_IRQ_MASK, 32'h1);
    pulse(4'h1);
    rdck(OFS_DIRECTION, 32'h87);
    check(32'(irq), 32'h1);
    pulse(4'h1);
    rdck(OFS_DIRECTION, 32'ha7);
    pulse(4'h4);
    rdck(OFS_DIRECTION, 32'h27);
    wr(OFS_DIRECTION, 32'h07);
    rdck(OFS_DIRECTION, 32'h07);
    pulse(4'h8);
    rdck(OFS_DIRECTION, 32'h47);
    pulse(4'h2);
    rdck(OFS_DIRECTION, 32'h07);
    rdck(OFS_IRQ_STATUS, 32'h7);
    wr(OFS_IRQ_STATUS, 32'h1);
    check(32'(irq), 32'h0);
    rdck(OFS_IRQ_STATUS, 32'h6);
    wr(OFS_IRQ_MASK, 32'h2);
    check(32'(irq), 32'h1);
    wr(OFS_IRQ_STATUS, 32'h6);
    check(32'(irq), 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    check(32'(rerr), 32'h1);
    check(rdata, 32'h0);
    $display("test events done");
    // a frozen block ignores events and must not answer a read with stale data
    clk_en <= 1'b0;
    pulse(4'h1);
    fork
      rdck(OFS_DIRECTION, 32'h07);
      begin
        repeat (3) @(posedge pclk);
        clk_en <= 1'b1;
      end
    join
    rdck(OFS_IRQ_STATUS, 32'h0);
    $display("test freeze done");
    test_done();
  end
endmodule
`default_nettype wire
